// file: hdl/aoc_params.svh
// register map, field positions and reset values of the analogue output block
// assumes: included by bare name from the module files
`ifndef AOC_PARAMS_SVH
`define AOC_PARAMS_SVH

// ==========================================
// unit registers, byte offsets
`define AOC_UNIT_CTRL_OFS 8'h00
`define AOC_IRQ_STAT_OFS 8'h04
`define AOC_IRQ_MASK_OFS 8'h08
`define AOC_DIAG_OFS 8'h0c

// ==========================================
// channel windows: base + channel * 0x20, word select inside
`define AOC_CH_BASE 8'h20
`define AOC_CH_WIN_SH 5
`define AOC_CH_CFG_SEL 3'h0
`define AOC_CH_VAL_SEL 3'h1
`define AOC_CH_UPR_SEL 3'h2
`define AOC_CH_LWR_SEL 3'h3
`define AOC_CH_FLT_SEL 3'h4
`define AOC_CH_IDL_SEL 3'h5
`define AOC_CH_CODE_SEL 3'h6

// ==========================================
// unit control fields and reset
`define AOC_SHORT_EN_BIT 0
`define AOC_HT_PRIO_BIT 1
`define AOC_SHORT_EN_RST 1'b1
`define AOC_HT_PRIO_RST 1'b0

// ==========================================
// channel fields and reset values
`define AOC_CFG_W 9
`define AOC_CFG_RST 9'h000
`define AOC_VAL_W 16
`define AOC_VAL_RST 16'h0000
`define AOC_UPR_RST 16'h03e8
`define AOC_LWR_RST 16'h0000
`define AOC_FLT_RST 16'h0000
`define AOC_IDL_RST 16'h0000
`define AOC_SCALE_UPR_MIN 16'h8002
`define AOC_SCALE_LWR_MAX 16'h7ffe
`define AOC_SCALE_LWR_MIN 16'h8001

`endif

// file: hdl/aoc_pkg.sv
// types shared by the analogue output channel logic
// assumes: nothing, not even the parameter header
package aoc_pkg;
  localparam int NCH = 2;
  localparam int CIW = 1;
  localparam int DIAG_W = 1 + 2 * NCH;

  typedef enum logic [2:0] {
    RNG_0_10V = 3'b000,
    RNG_0_5V = 3'b001,
    RNG_1_5V = 3'b010,
    RNG_0_20MA = 3'b011,
    RNG_4_20MA = 3'b100
  } range_e;

  typedef enum logic [1:0] {
    FMT_OFFSET = 2'b00,
    FMT_SIGN_MAG = 2'b01,
    FMT_TWOS = 2'b10,
    FMT_SCALED = 2'b11
  } format_e;

  typedef struct packed {
    logic idle_en;
    logic fault_en;
    logic lower_en;
    logic upper_en;
    format_e fmt;
    range_e range;
  } chan_cfg_s;
endpackage

// file: hdl/chan_if.sv
// bundle between the register side and one channel's drive logic
// assumes: one instance per channel, same clock on both ends
`timescale 1ns/1ps
interface chan_if;
  import aoc_pkg::*;
  chan_cfg_s cfg;
  logic [15:0] value;
  logic [15:0] upper;
  logic [15:0] lower;
  logic [15:0] fault_val;
  logic [15:0] idle_val;
  logic fault_act;
  logic idle_act;
  logic ht_prio;
  logic [15:0] code;
  logic upper_err;
  logic lower_err;

  modport ctrl (
    output cfg, value, upper, lower, fault_val, idle_val,
    output fault_act, idle_act, ht_prio,
    input code, upper_err, lower_err
  );
  modport chan (
    input cfg, value, upper, lower, fault_val, idle_val,
    input fault_act, idle_act, ht_prio,
    output code, upper_err, lower_err
  );
endinterface

// file: hdl/chan_drive.sv
// one output channel: value conversion, limit checks, fault/idle/hold selection
// assumes: fault and idle activity already synchronised to hclk
`timescale 1ns/1ps
module chan_drive
  import aoc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // channel bundle
  chan_if.chan ch
);
  logic [15:0] code_r;
  logic [15:0] code_nxt;
  logic [15:0] held_r;
  logic upper_err_r;
  logic lower_err_r;
  logic signed [15:0] sval;

  // ==========================================
  // value as signed count for comparison
  wire [15:0] mag_neg = (~{1'b0, ch.value[14:0]}) + 16'h0001;
  always_comb begin
    unique case (ch.cfg.fmt)
      FMT_OFFSET: sval = {~ch.value[15], ch.value[14:0]};
      FMT_SIGN_MAG: sval = ch.value[15] ? mag_neg : ch.value;
      FMT_TWOS: sval = ch.value;
      FMT_SCALED: sval = ch.value;
    endcase
  end

  // in scaled format the same comparators act on the scale limits
  wire up_hit = ch.cfg.upper_en && (sval > $signed(ch.upper));
  wire lo_hit = ch.cfg.lower_en && (sval < $signed(ch.lower));

  // ==========================================
  // output selection; fault outranks idle
  wire abnormal = ch.fault_act | ch.idle_act;
  wire use_fault = ch.ht_prio & ch.fault_act & ch.cfg.fault_en;
  wire use_idle = ch.ht_prio & ~ch.fault_act & ch.idle_act & ch.cfg.idle_en;
  assign code_nxt = use_fault ? ch.fault_val :
                    use_idle ? ch.idle_val :
                    abnormal ? held_r : ch.value;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_r <= 16'h0000;
      held_r <= 16'h0000;
      upper_err_r <= 1'b0;
      lower_err_r <= 1'b0;
    end else begin
      code_r <= code_nxt;
      upper_err_r <= up_hit;
      lower_err_r <= lo_hit;
      if (!abnormal) begin
        held_r <= ch.value;
      end
    end
  end

  assign ch.code = code_r;
  assign ch.upper_err = upper_err_r;
  assign ch.lower_err = lower_err_r;

  // ==========================================
  // checks
  sequence enter_hold_s;
    !abnormal ##1 (abnormal && !use_fault && !use_idle);
  endsequence

  fault_value_out_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    use_fault |=> ch.code == $past(ch.fault_val))
    else $error("fault value not driven");
  idle_value_out_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    use_idle |=> ch.code == $past(ch.idle_val))
    else $error("idle value not driven");
  hold_last_out_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    enter_hold_s |=> ch.code == $past(ch.value, 2))
    else $error("last value not held");
  prio_ignore_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (abnormal && !ch.ht_prio) |=> ch.code == $past(held_r))
    else $error("fault or idle setting used without priority");
  upper_flag_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ch.cfg.upper_en && sval > $signed(ch.upper)) |=> ch.upper_err)
    else $error("upper limit error missed");
  lower_flag_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ch.cfg.lower_en && sval < $signed(ch.lower)) |=> ch.lower_err)
    else $error("lower limit error missed");
  limit_off_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!ch.cfg.upper_en && !ch.cfg.lower_en) |=> !ch.upper_err && !ch.lower_err)
    else $error("limit error without enabled check");
endmodule

// file: hdl/analog_output_channel_config.sv
// unit control, AHB-Lite register file and supervision of all output channels
// assumes: AHB-Lite master on hclk; short, fault and idle arrive as async pins
`timescale 1ns/1ps
`include "aoc_params.svh"

module analog_output_channel_config
  import aoc_pkg::*;
(
  // bus clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // field side pins
  input wire logic supply_short,
  input wire logic comm_fault,
  input wire logic comm_idle,
  // channel codes to the converters
  output logic [NCH-1:0][15:0] chan_code,
  // interrupt
  output logic irq
);
  // ==========================================
  // pin synchronisers
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else begin
      pin_meta_r <= {supply_short, comm_idle, comm_fault};
      pin_sync_r <= pin_meta_r;
    end
  end

  wire fault_s = pin_sync_r[0];
  wire idle_s = pin_sync_r[1];
  wire short_s = pin_sync_r[2];

  // ==========================================
  // bus address and data phases
  logic [7:0] addr_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;

  wire bus_acc = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 8'h00;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end else begin
      wr_pend_r <= bus_acc & hwrite;
      rd_pend_r <= bus_acc & ~hwrite;
      if (bus_acc) begin
        addr_r <= haddr[7:0];
      end
    end
  end

  // reads take one wait state so the answer comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      hrdata_r <= rd_mux;
    end
  end

  assign hreadyout = ~rd_pend_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // ==========================================
  // address decode
  wire wr_en = wr_pend_r;
  wire [7:0] ch_off = addr_r - `AOC_CH_BASE;
  wire [7:0] ch_span = 8'(NCH << `AOC_CH_WIN_SH);
  wire ch_hit = (addr_r >= `AOC_CH_BASE) && (ch_off < ch_span);
  wire [CIW-1:0] ch_idx = ch_off[`AOC_CH_WIN_SH +: CIW];
  wire [2:0] reg_sel = ch_off[4:2];
  wire ctrl_hit = addr_r == `AOC_UNIT_CTRL_OFS;
  wire stat_hit = addr_r == `AOC_IRQ_STAT_OFS;
  wire mask_hit = addr_r == `AOC_IRQ_MASK_OFS;
  wire diag_hit = addr_r == `AOC_DIAG_OFS;

  // ==========================================
  // unit control
  logic short_en_r;
  logic ht_prio_r;
  logic short_err_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_en_r <= `AOC_SHORT_EN_RST;
      ht_prio_r <= `AOC_HT_PRIO_RST;
    end else if (wr_en && ctrl_hit) begin
      short_en_r <= hwdata[`AOC_SHORT_EN_BIT];
      ht_prio_r <= hwdata[`AOC_HT_PRIO_BIT];
    end
  end

  // flag follows the pin, so it drops once the short is gone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_err_r <= 1'b0;
    end else begin
      short_err_r <= short_en_r & short_s;
    end
  end

  // ==========================================
  // channel registers and drive logic
  chan_cfg_s cfg_r [NCH];
  logic [15:0] val_r [NCH];
  logic [15:0] upr_r [NCH];
  logic [15:0] lwr_r [NCH];
  logic [15:0] flt_r [NCH];
  logic [15:0] idl_r [NCH];
  logic [15:0] code_w [NCH];
  logic [2*NCH-1:0] ch_err;

  // out-of-span writes are clamped rather than refused, so a stray write
  // still leaves a limit that the comparators can reach, except an upper limit of 0x7fff, which has no ceiling clamp
  wire upr_low = $signed(hwdata[15:0]) < $signed(`AOC_SCALE_UPR_MIN);
  wire lwr_high = $signed(hwdata[15:0]) > $signed(`AOC_SCALE_LWR_MAX);
  wire lwr_low = $signed(hwdata[15:0]) < $signed(`AOC_SCALE_LWR_MIN);
  wire [15:0] upr_wdata = upr_low ? `AOC_SCALE_UPR_MIN : hwdata[15:0];
  wire [15:0] lwr_wdata = lwr_high ? `AOC_SCALE_LWR_MAX :
                          lwr_low ? `AOC_SCALE_LWR_MIN : hwdata[15:0];

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    chan_if cif();
    wire ch_wr = wr_en & ch_hit & (ch_idx == CIW'(c));

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cfg_r[c] <= chan_cfg_s'(`AOC_CFG_RST);
        val_r[c] <= `AOC_VAL_RST;
        upr_r[c] <= `AOC_UPR_RST;
        lwr_r[c] <= `AOC_LWR_RST;
        flt_r[c] <= `AOC_FLT_RST;
        idl_r[c] <= `AOC_IDL_RST;
      end else if (ch_wr) begin
        case (reg_sel)
          `AOC_CH_CFG_SEL: cfg_r[c] <= chan_cfg_s'(hwdata[`AOC_CFG_W-1:0]);
          `AOC_CH_VAL_SEL: val_r[c] <= hwdata[15:0];
          `AOC_CH_UPR_SEL: upr_r[c] <= upr_wdata;
          `AOC_CH_LWR_SEL: lwr_r[c] <= lwr_wdata;
          `AOC_CH_FLT_SEL: flt_r[c] <= hwdata[15:0];
          `AOC_CH_IDL_SEL: idl_r[c] <= hwdata[15:0];
          default: ;
        endcase
      end
    end

    assign cif.cfg = cfg_r[c];
    assign cif.value = val_r[c];
    assign cif.upper = upr_r[c];
    assign cif.lower = lwr_r[c];
    assign cif.fault_val = flt_r[c];
    assign cif.idle_val = idl_r[c];
    assign cif.fault_act = fault_s;
    assign cif.idle_act = idle_s;
    assign cif.ht_prio = ht_prio_r;

    chan_drive u_chan (
      .hclk(hclk),
      .hresetn(hresetn),
      .ch(cif)
    );

    assign code_w[c] = cif.code;
    assign chan_code[c] = cif.code;
    assign ch_err[2*c] = cif.upper_err;
    assign ch_err[2*c+1] = cif.lower_err;
  end

  // ==========================================
  // diagnostics and interrupt
  logic [DIAG_W-1:0] stat_r;
  logic [DIAG_W-1:0] mask_r;

  wire [DIAG_W-1:0] diag = {ch_err, short_err_r};
  wire [DIAG_W-1:0] w1c = (wr_en && stat_hit) ? hwdata[DIAG_W-1:0] : '0;
  // a new event in the clearing cycle wins over the clear
  wire [DIAG_W-1:0] stat_nxt = (stat_r & ~w1c) | diag;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      if (wr_en && mask_hit) begin
        mask_r <= hwdata[DIAG_W-1:0];
      end
    end
  end

  assign irq = |(stat_r & mask_r);

  // ==========================================
  // read selection
  wire [31:0] ctrl_rd = {30'h0, ht_prio_r, short_en_r};
  wire [31:0] cfg_rd = {23'h0, cfg_r[ch_idx]};
  wire [31:0] ch_rd =
    (reg_sel == `AOC_CH_CFG_SEL) ? cfg_rd :
    (reg_sel == `AOC_CH_VAL_SEL) ? {16'h0, val_r[ch_idx]} :
    (reg_sel == `AOC_CH_UPR_SEL) ? {16'h0, upr_r[ch_idx]} :
    (reg_sel == `AOC_CH_LWR_SEL) ? {16'h0, lwr_r[ch_idx]} :
    (reg_sel == `AOC_CH_FLT_SEL) ? {16'h0, flt_r[ch_idx]} :
    (reg_sel == `AOC_CH_IDL_SEL) ? {16'h0, idl_r[ch_idx]} :
    (reg_sel == `AOC_CH_CODE_SEL) ? {16'h0, code_w[ch_idx]} : 32'h0;
  wire [31:0] stat_rd = {{(32-DIAG_W){1'b0}}, stat_r};
  wire [31:0] mask_rd = {{(32-DIAG_W){1'b0}}, mask_r};
  wire [31:0] diag_rd = {{(32-DIAG_W){1'b0}}, diag};

  assign rd_mux = ctrl_hit ? ctrl_rd :
                  stat_hit ? stat_rd :
                  mask_hit ? mask_rd :
                  diag_hit ? diag_rd :
                  ch_hit ? ch_rd : 32'h0;

  // ==========================================
  // checks
  sequence read_req_s;
    bus_acc && !hwrite;
  endsequence

  sequence read_answer_s;
    !hreadyout ##1 hreadyout;
  endsequence

  read_wait_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    read_req_s |=> read_answer_s)
    else $error("read answer not after one wait state");
  short_raise_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (short_en_r && short_s) |=> diag[0])
    else $error("short circuit error not raised");
  short_off_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !short_en_r |=> !diag[0])
    else $error("short error raised while disabled");
  short_clear_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !short_s |=> !diag[0])
    else $error("short flag stays after condition ends");
  sticky_set_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    diag[1] |=> stat_r[1])
    else $error("status bit lost an event");
  upper_clamp_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_en && ch_hit && reg_sel == `AOC_CH_UPR_SEL && upr_low)
    |=> upr_r[$past(ch_idx)] == `AOC_SCALE_UPR_MIN)
    else $error("scale upper limit not clamped");
  lower_clamp_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_en && ch_hit && reg_sel == `AOC_CH_LWR_SEL && lwr_high)
    |=> lwr_r[$past(ch_idx)] == `AOC_SCALE_LWR_MAX)
    else $error("scale lower limit not clamped");
  fault_pin_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ht_prio_r && fault_s && cfg_r[0].fault_en) [*2]
    |=> chan_code[0] == $past(flt_r[0]))
    else $error("channel 0 not at fault value");
  idle_pin_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ht_prio_r && idle_s && !fault_s && cfg_r[0].idle_en)
    |=> chan_code[0] == $past(idl_r[0]))
    else $error("channel 0 not at idle value");
  lower_floor_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_en && ch_hit && reg_sel == `AOC_CH_LWR_SEL && lwr_low)
    |=> lwr_r[$past(ch_idx)] == `AOC_SCALE_LWR_MIN)
    else $error("scale lower limit below floor");
  upper_off_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !cfg_r[0].upper_en |=> !diag[1])
    else $error("channel 0 upper flag without check");
  lower_off_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !cfg_r[1].lower_en |=> !diag[4])
    else $error("channel 1 lower flag without check");

  // ==========================================
  // hold without priority: once a fault or idle spell has lasted two
  // cycles the driven codes must not move, whatever the channel settings
  sequence unprio_abn_s;
    (fault_s || idle_s) && !ht_prio_r;
  endsequence

  prio_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    unprio_abn_s ##1 unprio_abn_s |=> $stable(chan_code))
    else $error("code moved while priority off");

  // ==========================================
  // bus timing and sticky status
  // sticky bits may only fall through a write of one to the status word
  write_nowait_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (bus_acc && hwrite) |=> hreadyout)
    else $error("write stalled the bus");
  rdata_hold_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !rd_pend_r |=> $stable(hrdata))
    else $error("read data moved without a read");
  stat_keep_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(wr_en && stat_hit) |=> (stat_r & $past(stat_r)) == $past(stat_r))
    else $error("status bit dropped without a clear");
endmodule

// file: tb/fieldbus_master.sv
// far side model: fieldbus master pins for communication state and supply short
// assumes: bench raises requests on hclk, pins change right after a rising edge
`timescale 1ns/1ps
module fieldbus_master (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // requests from the bench
  input wire logic fault_req,
  input wire logic idle_req,
  input wire logic short_req,
  // pins to the device
  output logic comm_fault,
  output logic comm_idle,
  output logic supply_short
);
  // ==========================================
  // pin drive
  // levels, held for as long as the condition lasts; set values stay the bench's job
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comm_fault <= 1'b0;
      comm_idle <= 1'b0;
      supply_short <= 1'b0;
    end else begin
      comm_fault <= fault_req;
      comm_idle <= idle_req;
      supply_short <= short_req;
    end
  end
endmodule

// file: tb/testbench.sv
// self-checking bench: AHB-Lite register traffic plus field pins via the master model
// assumes: design sources compiled first, hready looped back from hreadyout
`timescale 1ns/1ps
`include "aoc_params.svh"
module testbench;
  import aoc_pkg::*;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic fault_req, idle_req, short_req;
  wire logic hreadyout, hresp, irq, supply_short, comm_fault, comm_idle;
  wire logic [31:0] hrdata;
  wire logic [NCH-1:0][15:0] chan_code;
  int mismatches, check_count;

  // ==========================================
  // instances
  analog_output_channel_config i_analog_output_channel_config (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .supply_short(supply_short),
    .comm_fault(comm_fault), .comm_idle(comm_idle), .chan_code(chan_code), .irq(irq));
  fieldbus_master i_fieldbus_master (
    .hclk(hclk), .hresetn(hresetn), .fault_req(fault_req), .idle_req(idle_req),
    .short_req(short_req), .comm_fault(comm_fault), .comm_idle(comm_idle),
    .supply_short(supply_short));

  // ==========================================
  // helpers
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // one single transfer; entered just after a rising edge, leaves at the answering edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
    int n;
    n = 0;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin
      mismatches++;
      $display("[ERR] %0t ns: bus answer missing", $time);
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, a, 32'h00000000, x);
    chk(x, exp);
    chk({31'h0, hresp}, 32'h00000000);
  endtask

  function automatic logic [7:0] ca(input int c, input logic [2:0] s);
    return `AOC_CH_BASE + 8'(c << `AOC_CH_WIN_SH) + {3'b000, s, 2'b00};
  endfunction

  // ==========================================
  // scenarios
  task automatic t_reset();
    chk({16'h0000, chan_code[0]}, 32'h00000000);
    chk({31'h0, irq}, 32'h00000000);
    rchk(`AOC_UNIT_CTRL_OFS, 32'h00000001);
    rchk(`AOC_IRQ_STAT_OFS, 32'h00000000);
    rchk(`AOC_IRQ_MASK_OFS, 32'h00000000);
    rchk(ca(1, `AOC_CH_CFG_SEL), 32'h00000000);
    rchk(ca(0, `AOC_CH_UPR_SEL), 32'h000003e8);
    rchk(ca(0, `AOC_CH_LWR_SEL), 32'h00000000);
    wr(8'h10, 32'hffffffff);
    rchk(8'h10, 32'h00000000);
    wr(ca(0, `AOC_CH_UPR_SEL), 32'h00008000);
    rchk(ca(0, `AOC_CH_UPR_SEL), 32'h00008002);
    wr(ca(0, `AOC_CH_UPR_SEL), 32'h00007fff);
    rchk(ca(0, `AOC_CH_UPR_SEL), 32'h00007fff);
    wr(ca(0, `AOC_CH_LWR_SEL), 32'h00007fff);
    rchk(ca(0, `AOC_CH_LWR_SEL), 32'h00007ffe);
    wr(ca(0, `AOC_CH_LWR_SEL), 32'h00008000);
    rchk(ca(0, `AOC_CH_LWR_SEL), 32'h00008001);
    wr(ca(0, `AOC_CH_LWR_SEL), 32'h00008001);
    rchk(ca(0, `AOC_CH_LWR_SEL), 32'h00008001);
    $display("test reset and clamps done");
  endtask

  // same upper limit test under each format; the value words differ from run to run, the last two runs share a limit word
  task automatic t_formats();
    logic [15:0] up [5] = '{16'h0000, 16'hfffc, 16'h0004, 16'h03e8, 16'h03e8};
    logic [15:0] vl [5] = '{16'h8001, 16'h8003, 16'hfff0, 16'h03e9, 16'h03e8};
    logic ex [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      wr(ca(0, `AOC_CH_CFG_SEL), 32'((i % 4) << 3) | 32'h00000020);
      wr(ca(0, `AOC_CH_UPR_SEL), {16'h0000, up[i]});
      wr(ca(0, `AOC_CH_VAL_SEL), {16'h0000, vl[i]});
      rchk(`AOC_DIAG_OFS, {30'h0, ex[i], 1'b0});
    end
    wr(ca(0, `AOC_CH_CFG_SEL), 32'h00000018);
    wr(ca(0, `AOC_CH_VAL_SEL), 32'h00007000);
    rchk(`AOC_DIAG_OFS, 32'h00000000);
    $display("test formats and upper limit done");
  endtask

  task automatic t_lower();
    wr(ca(1, `AOC_CH_CFG_SEL), 32'h00000050);
    wr(ca(1, `AOC_CH_LWR_SEL), 32'h0000fffb);
    wr(ca(1, `AOC_CH_VAL_SEL), 32'h0000fffa);
    rchk(`AOC_DIAG_OFS, 32'h00000010);
    wr(ca(1, `AOC_CH_VAL_SEL), 32'h0000fffb);
    rchk(`AOC_DIAG_OFS, 32'h00000000);
    wr(ca(1, `AOC_CH_CFG_SEL), 32'h00000058);
    wr(ca(1, `AOC_CH_VAL_SEL), 32'h00008000);
    rchk(`AOC_DIAG_OFS, 32'h00000010);
    wr(ca(1, `AOC_CH_VAL_SEL), 32'h00000000);
    $display("test lower limit done");
  endtask

  task automatic t_irq();
    rchk(`AOC_IRQ_STAT_OFS, 32'h00000012);
    chk({31'h0, irq}, 32'h00000000);
    wr(`AOC_IRQ_MASK_OFS, 32'h00000010);
    waitc(1);
    chk({31'h0, irq}, 32'h00000001);
    wr(`AOC_IRQ_STAT_OFS, 32'h00000012);
    waitc(2);
    rchk(`AOC_IRQ_STAT_OFS, 32'h00000000);
    chk({31'h0, irq}, 32'h00000000);
    $display("test interrupt done");
  endtask

  task automatic t_short();
    short_req <= 1'b1;
    waitc(6);
    rchk(`AOC_DIAG_OFS, 32'h00000001);
    chk({31'h0, irq}, 32'h00000000);
    wr(`AOC_UNIT_CTRL_OFS, 32'h00000000);
    waitc(3);
    rchk(`AOC_DIAG_OFS, 32'h00000000);
    wr(`AOC_UNIT_CTRL_OFS, 32'h00000001);
    waitc(3);
    rchk(`AOC_DIAG_OFS, 32'h00000001);
    short_req <= 1'b0;
    waitc(6);
    rchk(`AOC_DIAG_OFS, 32'h00000000);
    $display("test supply short done");
  endtask

  task automatic t_fault_idle();
    wr(ca(0, `AOC_CH_CFG_SEL), {23'h0, 9'h180});
    wr(ca(0, `AOC_CH_VAL_SEL), 32'h00001111);
    wr(ca(0, `AOC_CH_IDL_SEL), 32'h00000bbb);
    wr(ca(1, `AOC_CH_CFG_SEL), 32'h00000000);
    wr(ca(1, `AOC_CH_VAL_SEL), 32'h00000777);
    // range changed, so the fault value is rewritten inside the new span
    wr(ca(0, `AOC_CH_CFG_SEL), {23'h0, 9'h180} | 32'(RNG_0_5V));
    wr(ca(0, `AOC_CH_FLT_SEL), 32'h00000555);
    fault_req <= 1'b1;
    waitc(6);
    chk({16'h0000, chan_code[0]}, 32'h00001111);
    wr(`AOC_UNIT_CTRL_OFS, 32'h00000003);
    waitc(2);
    chk({16'h0000, chan_code[0]}, 32'h00000555);
    chk({16'h0000, chan_code[1]}, 32'h00000777);
    wr(ca(1, `AOC_CH_VAL_SEL), 32'h00000999);
    waitc(2);
    rchk(ca(1, `AOC_CH_CODE_SEL), 32'h00000777);
    idle_req <= 1'b1;
    waitc(6);
    chk({16'h0000, chan_code[0]}, 32'h00000555);
    fault_req <= 1'b0;
    waitc(6);
    chk({16'h0000, chan_code[0]}, 32'h00000bbb);
    chk({16'h0000, chan_code[1]}, 32'h00000777);
    idle_req <= 1'b0;
    waitc(6);
    chk({16'h0000, chan_code[0]}, 32'h00001111);
    chk({16'h0000, chan_code[1]}, 32'h00000999);
    $display("test fault and idle output done");
  endtask

  // ==========================================
  // clock, reset, sequence, watchdog
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    fault_req = 1'b0;
    idle_req = 1'b0;
    short_req = 1'b0;
    mismatches = 0;
    check_count = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_formats();
    t_lower();
    t_irq();
    t_short();
    t_fault_idle();
    tally_and_finish();
  end

  // the whole run needs well under two thousand cycles
  initial begin
    #40000;
    mismatches++;
    $display("[ERR] %0t ns: run did not complete", $time);
    tally_and_finish();
  end
endmodule
